// ===== design/cb_status_pkg.sv
// Constants for the secondary status and bus number register block
`default_nettype none
package cb_status_pkg;
  // Configuration byte offsets
  localparam logic [7:0] OFF_STATUS    = 8'h16;
  localparam logic [7:0] OFF_PRIMARY   = 8'h18;
  localparam logic [7:0] OFF_SECONDARY = 8'h19;
  localparam logic [7:0] OFF_HIGHEST   = 8'h1A;
  // Dword indices holding them
  localparam logic [5:0] DW_STATUS     = OFF_STATUS[7:2];
  localparam logic [5:0] DW_BUSNUM     = OFF_PRIMARY[7:2];
  // Status field positions
  localparam int BIT_PARITY_DET   = 15;
  localparam int BIT_SERR_SEEN    = 14;
  localparam int BIT_MABORT_RCV   = 13;
  localparam int BIT_TABORT_RCV   = 12;
  localparam int BIT_TABORT_SIG   = 11;
  localparam int BIT_DECODE_HI    = 10;
  localparam int BIT_DECODE_LO    = 9;
  localparam int BIT_DPAR_REP     = 8;
  localparam int BIT_B2B_CAP      = 7;
  localparam int BIT_USER_FEAT    = 6;
  localparam int BIT_FAST_CLK     = 5;
  localparam logic [1:0]  SELECT_DECODE_TIMING = 2'h1;
  localparam logic [15:0] STATUS_RESET         = 16'h0200;
  localparam logic [15:0] CLEARABLE_MASK       = 16'hF900;
  localparam logic [7:0]  BUSNUM_RESET         = 8'h00;
  // Byte lanes within the dwords
  localparam int LANE_STATUS_LO = 2;
  localparam int LANE_STATUS_HI = 3;
  localparam int LANE_PRIMARY   = 0;
  localparam int LANE_SECONDARY = 1;
  localparam int LANE_HIGHEST   = 2;
  // Card clock limit
  localparam longint SYS_CLK_HZ   = 50_000_000;
  localparam longint CARD_CLK_MAX = 33_000_000;
  localparam int     CARD_HALF_CYC =
    int'((SYS_CLK_HZ + 2 * CARD_CLK_MAX - 1) / (2 * CARD_CLK_MAX));
  localparam logic [3:0] CARD_HALF_CNT = 4'(CARD_HALF_CYC - 1);
endpackage
`default_nettype wire

// ===== design/cardbus_secondary_status_busnum.sv
// Secondary status, bus number registers and configuration forward decode
`default_nettype none
module cardbus_secondary_status_busnum (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_global_reset_n,
  // Configuration access
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [5:0]  i_cfg_dword,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic [31:0]      o_cfg_rdata,
  output logic             o_cfg_rvalid,
  // Error events from secondary bus logic
  input  wire logic        i_addr_parity_err,
  input  wire logic        i_data_parity_err,
  input  wire logic        i_master_abort_rcvd,
  input  wire logic        i_target_abort_rcvd,
  input  wire logic        i_target_abort_sig,
  input  wire logic        i_bus_master_dphase,
  input  wire logic        i_parity_resp_en,
  // Card pins
  input  wire logic        i_card_serr_n,
  output logic             o_card_serr_out,
  output logic             o_card_serr_oe,
  input  wire logic        i_card_perr_n,
  output logic             o_card_clk,
  // Configuration cycle forward decode
  input  wire logic        i_fwd_req,
  input  wire logic        i_fwd_type1,
  input  wire logic [7:0]  i_fwd_bus,
  output logic             o_fwd_valid,
  output logic             o_fwd_as_type0,
  output logic             o_fwd_as_type1,
  output logic             o_fwd_none,
  output logic [15:0]      o_status
);
  import cb_status_pkg::*;

  // Pin synchronisers
  logic global_reset_n_s1_r;
  logic global_reset_n_s1_nxt;
  logic global_reset_n_s2_r;
  logic global_reset_n_s2_nxt;
  logic serr_s1_r;
  logic serr_s1_nxt;
  logic serr_s2_r;
  logic serr_s2_nxt;
  logic perr_s1_r;
  logic perr_s1_nxt;
  logic perr_s2_r;
  logic perr_s2_nxt;
  logic mstr_d1_r;
  logic mstr_d1_nxt;
  logic mstr_d2_r;
  logic mstr_d2_nxt;
  logic pen_d1_r;
  logic pen_d1_nxt;
  logic pen_d2_r;
  logic pen_d2_nxt;

  // Keep mastership aligned with the synchronised parity pin
  always_comb begin
    global_reset_n_s1_nxt = i_global_reset_n;
    global_reset_n_s2_nxt = global_reset_n_s1_r;
    serr_s1_nxt = i_card_serr_n;
    serr_s2_nxt = serr_s1_r;
    perr_s1_nxt = i_card_perr_n;
    perr_s2_nxt = perr_s1_r;
    mstr_d1_nxt = i_bus_master_dphase;
    mstr_d2_nxt = mstr_d1_r;
    pen_d1_nxt  = i_parity_resp_en;
    pen_d2_nxt  = pen_d1_r;
  end

  always_ff @(posedge i_clk) begin
    global_reset_n_s1_r <= global_reset_n_s1_nxt;
    global_reset_n_s2_r <= global_reset_n_s2_nxt;
    serr_s1_r <= serr_s1_nxt;
    serr_s2_r <= serr_s2_nxt;
    perr_s1_r <= perr_s1_nxt;
    perr_s2_r <= perr_s2_nxt;
    mstr_d1_r <= mstr_d1_nxt;
    mstr_d2_r <= mstr_d2_nxt;
    pen_d1_r  <= pen_d1_nxt;
    pen_d2_r  <= pen_d2_nxt;
  end

  logic global_rst;
  assign global_rst = ~global_reset_n_s2_r;

  // The card alone drives its error line
  assign o_card_serr_out = 1'b0;
  assign o_card_serr_oe  = 1'b0;

  // Access decode
  logic wr_status_hi;
  logic wr_busnum;
  assign wr_status_hi = i_cfg_wr && (i_cfg_dword == DW_STATUS) && i_cfg_be[LANE_STATUS_HI];
  assign wr_busnum    = i_cfg_wr && (i_cfg_dword == DW_BUSNUM);

  // Error flag group
  logic [15:0] flags_r;
  logic [15:0] flags_nxt;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;

  always_comb begin
    set_vec = 16'h0000;
    set_vec[BIT_PARITY_DET] = i_addr_parity_err | i_data_parity_err;
    set_vec[BIT_SERR_SEEN]  = ~serr_s2_r;
    set_vec[BIT_MABORT_RCV] = i_master_abort_rcvd;
    set_vec[BIT_TABORT_RCV] = i_target_abort_rcvd;
    set_vec[BIT_TABORT_SIG] = i_target_abort_sig;
    set_vec[BIT_DPAR_REP]   = ~perr_s2_r & mstr_d2_r & pen_d2_r;
    clr_vec = 16'h0000;
    if (wr_status_hi) begin
      clr_vec[15:8] = i_cfg_wdata[31:24];
    end
    // A new event in the clearing cycle survives
    flags_nxt = ((flags_r & ~clr_vec) | set_vec) & CLEARABLE_MASK;
    if (global_rst) begin
      flags_nxt = 16'h0000;
    end
  end

  // Of the two resets only the global one touches these flags
  always_ff @(posedge i_clk) begin
    flags_r <= flags_nxt;
  end

  logic [15:0] status_view;
  always_comb begin
    status_view = flags_r & CLEARABLE_MASK;
    status_view[BIT_DECODE_HI:BIT_DECODE_LO] = SELECT_DECODE_TIMING;
    status_view[BIT_B2B_CAP]   = 1'b0;
    status_view[BIT_USER_FEAT] = 1'b0;
    status_view[BIT_FAST_CLK]  = 1'b0;
    status_view[4:0]           = 5'h00;
  end
  assign o_status = status_view;

  // Bus number group
  logic [7:0] primary_bus_index_r;
  logic [7:0] primary_bus_index_nxt;
  logic [7:0] secondary_bus_index_r;
  logic [7:0] secondary_bus_index_nxt;
  logic [7:0] highest_downstream_bus_index_r;
  logic [7:0] highest_downstream_bus_index_nxt;

  always_comb begin
    primary_bus_index_nxt            = primary_bus_index_r;
    secondary_bus_index_nxt          = secondary_bus_index_r;
    highest_downstream_bus_index_nxt = highest_downstream_bus_index_r;
    if (wr_busnum && i_cfg_be[LANE_PRIMARY]) begin
      primary_bus_index_nxt = i_cfg_wdata[7:0];
    end
    if (wr_busnum && i_cfg_be[LANE_SECONDARY]) begin
      secondary_bus_index_nxt = i_cfg_wdata[15:8];
    end
    if (wr_busnum && i_cfg_be[LANE_HIGHEST]) begin
      highest_downstream_bus_index_nxt = i_cfg_wdata[23:16];
    end
    // Global reset clears these as well as the local one
    if (!i_rst_n || global_rst) begin
      primary_bus_index_nxt            = BUSNUM_RESET;
      secondary_bus_index_nxt          = BUSNUM_RESET;
      highest_downstream_bus_index_nxt = BUSNUM_RESET;
    end
  end

  always_ff @(posedge i_clk) begin
    primary_bus_index_r            <= primary_bus_index_nxt;
    secondary_bus_index_r          <= secondary_bus_index_nxt;
    highest_downstream_bus_index_r <= highest_downstream_bus_index_nxt;
  end

  // Read answer group
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;

  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    // A read that meets a write is dropped
    if (i_cfg_rd && !i_cfg_wr) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = 32'h0000_0000;
      unique case (i_cfg_dword)
        DW_STATUS: begin
          if (i_cfg_be[LANE_STATUS_LO]) begin
            rdata_nxt[23:16] = status_view[7:0];
          end
          if (i_cfg_be[LANE_STATUS_HI]) begin
            rdata_nxt[31:24] = status_view[15:8];
          end
        end
        DW_BUSNUM: begin
          if (i_cfg_be[LANE_PRIMARY]) begin
            rdata_nxt[7:0] = primary_bus_index_r;
          end
          if (i_cfg_be[LANE_SECONDARY]) begin
            rdata_nxt[15:8] = secondary_bus_index_r;
          end
          if (i_cfg_be[LANE_HIGHEST]) begin
            rdata_nxt[23:16] = highest_downstream_bus_index_r;
          end
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
    if (!i_rst_n) begin
      rdata_nxt  = 32'h0000_0000;
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    rdata_r  <= rdata_nxt;
    rvalid_r <= rvalid_nxt;
  end

  assign o_cfg_rdata  = rdata_r;
  assign o_cfg_rvalid = rvalid_r;

  // Configuration forward decode group
  logic fwd_valid_r;
  logic fwd_valid_nxt;
  logic fwd_t0_r;
  logic fwd_t0_nxt;
  logic fwd_t1_r;
  logic fwd_t1_nxt;
  logic fwd_none_r;
  logic fwd_none_nxt;
  logic hit_secondary;
  logic hit_below;
  logic own_bus;
  // Our own bus number is never forwarded

  always_comb begin
    own_bus       = (i_fwd_bus == primary_bus_index_r);
    hit_secondary = (i_fwd_bus == secondary_bus_index_r);
    hit_below     = (i_fwd_bus > secondary_bus_index_r) &&
                    (i_fwd_bus <= highest_downstream_bus_index_r);
    fwd_valid_nxt = 1'b0;
    fwd_t0_nxt    = 1'b0;
    fwd_t1_nxt    = 1'b0;
    fwd_none_nxt  = 1'b0;
    if (i_fwd_req) begin
      fwd_valid_nxt = 1'b1;
      if (i_fwd_type1 && !own_bus && hit_secondary) begin
        fwd_t0_nxt = 1'b1;
      end else if (i_fwd_type1 && !own_bus && hit_below) begin
        fwd_t1_nxt = 1'b1;
      end else begin
        fwd_none_nxt = 1'b1;
      end
    end
    if (!i_rst_n) begin
      fwd_valid_nxt = 1'b0;
      fwd_t0_nxt    = 1'b0;
      fwd_t1_nxt    = 1'b0;
      fwd_none_nxt  = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    fwd_valid_r <= fwd_valid_nxt;
    fwd_t0_r    <= fwd_t0_nxt;
    fwd_t1_r    <= fwd_t1_nxt;
    fwd_none_r  <= fwd_none_nxt;
  end

  assign o_fwd_valid    = fwd_valid_r;
  assign o_fwd_as_type0 = fwd_t0_r;
  assign o_fwd_as_type1 = fwd_t1_r;
  assign o_fwd_none     = fwd_none_r;

  // Card clock divider, half period rounded up to stay under the limit
  logic [3:0] cclk_cnt_r;
  logic [3:0] cclk_cnt_nxt;
  logic       cclk_half_en;
  logic       cclk_r;
  logic       cclk_nxt;

  always_comb begin
    cclk_cnt_nxt = cclk_cnt_r - 4'h1;
    cclk_half_en = 1'b0;
    if (cclk_cnt_r == 4'h0) begin
      cclk_cnt_nxt = CARD_HALF_CNT;
      cclk_half_en = 1'b1;
    end
    if (!i_rst_n) begin
      cclk_cnt_nxt = CARD_HALF_CNT;
      cclk_half_en = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    cclk_cnt_r <= cclk_cnt_nxt;
  end

  // Pin level flips once per enable pulse
  always_comb begin
    cclk_nxt = cclk_r;
    if (cclk_half_en) begin
      cclk_nxt = ~cclk_r;
    end
    if (!i_rst_n) begin
      cclk_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    cclk_r <= cclk_nxt;
  end

  assign o_card_clk = cclk_r;

endmodule // cardbus_secondary_status_busnum
`default_nettype wire

// ===== testbench/sec_status_checker.sv
// Port assertions for the secondary status and bus number block
`default_nettype none
module sec_status_checker (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_global_reset_n,
  input wire logic        i_cfg_wr,
  input wire logic [5:0]  i_cfg_dword,
  input wire logic [3:0]  i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic        i_master_abort_rcvd,
  input wire logic        i_bus_master_dphase,
  input wire logic        i_parity_resp_en,
  input wire logic        i_card_serr_n,
  input wire logic        i_card_perr_n,
  input wire logic        i_fwd_req,
  input wire logic        o_fwd_valid,
  input wire logic        o_fwd_as_type0,
  input wire logic        o_fwd_as_type1,
  input wire logic        o_fwd_none,
  input wire logic        o_card_serr_oe,
  input wire logic [15:0] o_status
);
  import cb_status_pkg::*;
  logic [2:0] quiet_r;
  logic [2:0] quiet_nxt;
  logic       quiet;
  // Edges since global reset release, saturating
  always_comb quiet_nxt = !i_global_reset_n ? 3'h0 : quiet_r + 3'(quiet_r != 3'h7);
  always_ff @(posedge i_clk) quiet_r <= quiet_nxt;
  assign quiet = quiet_r[2];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_clear13;
    i_cfg_wr && i_cfg_dword == DW_STATUS && i_cfg_be[3] && i_cfg_wdata[29];
  endsequence
  sequence s_dpar;
    quiet && !i_card_perr_n && i_bus_master_dphase && i_parity_resp_en;
  endsequence
  sequence s_fwd_one;
    o_fwd_valid && $onehot({o_fwd_as_type0, o_fwd_as_type1, o_fwd_none});
  endsequence
  property p_clear; s_clear13 ##0 !i_master_abort_rcvd |=> !o_status[BIT_MABORT_RCV]; endproperty
  property p_mabort; quiet && i_master_abort_rcvd |=> o_status[BIT_MABORT_RCV]; endproperty
  property p_fixed; o_status[10:9] == SELECT_DECODE_TIMING && o_status[7:0] == 8'h00; endproperty
  property p_no_drive; !o_card_serr_oe; endproperty
  property p_serr; quiet && !i_card_serr_n |-> ##3 o_status[BIT_SERR_SEEN]; endproperty
  property p_dpar; s_dpar |-> ##3 o_status[BIT_DPAR_REP]; endproperty
  property p_keep;
    @(posedge i_clk) disable iff (!i_global_reset_n)
    quiet && !i_rst_n && o_status[BIT_MABORT_RCV] |=> o_status[BIT_MABORT_RCV];
  endproperty
  property p_fwd; i_fwd_req |=> s_fwd_one; endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared by write");
  a_mabort: assert property (p_mabort) else $error("master abort flag not set");
  a_fixed: assert property (p_fixed) else $error("fixed status bits wrong");
  a_no_drive: assert property (p_no_drive) else $error("card error pin driven");
  a_serr: assert property (p_serr) else $error("card error flag not set");
  a_dpar: assert property (p_dpar) else $error("data parity flag not set");
  a_keep: assert property (p_keep) else $error("flag lost in local reset");
  a_fwd: assert property (p_fwd) else $error("forward result malformed");
endmodule // sec_status_checker
bind cardbus_secondary_status_busnum sec_status_checker i_sec_status_checker (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_global_reset_n(i_global_reset_n),
  .i_cfg_wr(i_cfg_wr), .i_cfg_dword(i_cfg_dword), .i_cfg_be(i_cfg_be),
  .i_cfg_wdata(i_cfg_wdata), .i_master_abort_rcvd(i_master_abort_rcvd),
  .i_bus_master_dphase(i_bus_master_dphase), .i_parity_resp_en(i_parity_resp_en),
  .i_card_serr_n(i_card_serr_n), .i_card_perr_n(i_card_perr_n), .i_fwd_req(i_fwd_req),
  .o_fwd_valid(o_fwd_valid), .o_fwd_as_type0(o_fwd_as_type0),
  .o_fwd_as_type1(o_fwd_as_type1), .o_fwd_none(o_fwd_none),
  .o_card_serr_oe(o_card_serr_oe), .o_status(o_status));
`default_nettype wire

// ===== testbench/cb_card_model.sv
// Card side model of the error pins
`default_nettype none
module cb_card_model (
  input  wire logic i_serr_cmd,
  input  wire logic i_perr_cmd,
  input  wire logic i_serr_out,
  input  wire logic i_serr_oe,
  output logic      o_serr_n,
  output logic      o_perr_n
);
  // Pulled-up pins; bridge joins in only if enabled
  assign o_serr_n = !i_serr_cmd && !(i_serr_oe && !i_serr_out);
  assign o_perr_n = !i_perr_cmd;
endmodule // cb_card_model
`default_nettype wire

// ===== testbench/test_cardbus_secondary_status_busnum.sv
// Self-checking bench for the secondary status and bus number block
`default_nettype none
module test_cardbus_secondary_status_busnum;
  timeunit 1ns;
  timeprecision 1ns;
  import cb_status_pkg::*;
  logic clk = 0, rst_n = 0, global_reset_n_n = 0, wr = 0, rd = 0, req = 0, t1 = 0;
  logic serr_cmd = 0, perr_cmd = 0, mst = 0, pen = 0, rv, fv, f0, f1, fn, so, soe, sn, pn, cclk;
  logic [4:0]  ev = 0;
  logic [5:0]  dw = 0;
  logic [3:0]  be = 0;
  logic [7:0]  bus = 0;
  logic [31:0] wd = 0, m, rdat;
  logic [15:0] sts;
  int fails = 0, check_count = 0, pri = 0, sec = 0, hi = 0, st = 'h0200, n = 0, cl = 0, q[$];
  int fb[5] = '{15, 15, 13, 12, 11};
  cardbus_secondary_status_busnum i_cardbus_secondary_status_busnum (
    .i_clk(clk), .i_rst_n(rst_n), .i_global_reset_n(global_reset_n_n), .i_cfg_wr(wr), .i_cfg_rd(rd),
    .i_cfg_dword(dw), .i_cfg_be(be), .i_cfg_wdata(wd), .o_cfg_rdata(rdat), .o_cfg_rvalid(rv),
    .i_addr_parity_err(ev[0]), .i_data_parity_err(ev[1]), .i_master_abort_rcvd(ev[2]),
    .i_target_abort_rcvd(ev[3]), .i_target_abort_sig(ev[4]), .i_bus_master_dphase(mst),
    .i_parity_resp_en(pen), .i_card_serr_n(sn), .o_card_serr_out(so), .o_card_serr_oe(soe),
    .i_card_perr_n(pn), .o_card_clk(cclk), .i_fwd_req(req), .i_fwd_type1(t1), .i_fwd_bus(bus),
    .o_fwd_valid(fv), .o_fwd_as_type0(f0), .o_fwd_as_type1(f1), .o_fwd_none(fn), .o_status(sts));
  cb_card_model i_cb_card_model (.i_serr_cmd(serr_cmd), .i_perr_cmd(perr_cmd),
    .i_serr_out(so), .i_serr_oe(soe), .o_serr_n(sn), .o_perr_n(pn));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cfg_wr(input logic [5:0] d, input logic [31:0] v, input logic [3:0] b = 4'hF);
    @(posedge clk);
    wr <= 1;
    dw <= d;
    be <= b;
    wd <= v;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic cfg_rd(input logic [5:0] d, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1;
    dw <= d;
    be <= 4'hF;
    @(posedge clk);
    rd <= 0;
    #1;
    check(rv, 1'b1);
    check(rdat, exp);
  endtask
  task automatic rd_status();
    cfg_rd(DW_STATUS, {16'(st), 16'h0000});
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1;
    @(posedge clk);
    ev[i] <= 0;
    st |= 1 << fb[i];
  endtask
  task automatic fwd(input logic t, input int b);
    logic e0, e1;
    @(posedge clk);
    req <= 1;
    t1 <= t;
    bus <= 8'(b);
    @(posedge clk);
    req <= 0;
    e0 = t && b != pri && b == sec;
    e1 = t && b != pri && b > sec && b <= hi;
    #1;
    check({fv, f0, f1, fn}, {1'b1, e0, e1, !(e0 || e1)});
  endtask
  initial forever #10 clk = ~clk;
  initial begin
    #100us;
    fails++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h75B5));
    tick(8);
    global_reset_n_n <= 1;
    tick(8);
    rst_n <= 1;
    tick(3);
    rd_status();
    cfg_rd(DW_BUSNUM, 32'h0000_0000);
    cfg_rd(6'h3F, 32'h0000_0000);
    pri = $urandom_range(9);
    sec = pri + 1 + $urandom_range(9);
    hi = sec + 2 + $urandom_range(9);
    cfg_wr(DW_BUSNUM, {8'($urandom), 8'(hi), 8'(sec), 8'(pri)});
    cfg_rd(DW_BUSNUM, {8'h00, 8'(hi), 8'(sec), 8'(pri)});
    cfg_wr(DW_BUSNUM, 32'hFFFF_FFFF, 4'h8);
    cfg_rd(DW_BUSNUM, {8'h00, 8'(hi), 8'(sec), 8'(pri)});
    q = '{pri, sec, sec + 1, hi, hi + 1};
    foreach (q[k]) begin
      fwd(1'b1, q[k]);
      fwd(1'b0, q[k]);
    end
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      rd_status();
      m = $urandom;
      cfg_wr(DW_STATUS, m);
      st &= ~(int'(m[31:16]) & 'hF900);
      rd_status();
    end
    cfg_wr(DW_STATUS, 32'hFFFF_FFFF);
    st = 'h0200;
    @(posedge clk);
    serr_cmd <= 1;
    @(posedge clk);
    serr_cmd <= 0;
    tick(4);
    st |= 'h4000;
    rd_status();
    cfg_wr(DW_STATUS, 32'hFFFF_FFFF, 4'h7);
    rd_status();
    check(soe, 1'b0);
    check(so, 1'b0);
    cl = cclk;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      n += int'(cclk && !cl);
      cl = cclk;
    end
    check(32'(n), 32'(40 / (2 * CARD_HALF_CYC)));
    check(32'(n * 1000 <= 40 * 20 * 33), 32'h1);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      perr_cmd <= c[2];
      mst <= c[0];
      pen <= c[1];
      @(posedge clk);
      perr_cmd <= 0;
      mst <= 0;
      pen <= 0;
      tick(4);
      if (c == 7) st |= 'h0100;
      rd_status();
    end
    pulse(2);
    @(posedge clk);
    rst_n <= 0;
    tick(3);
    rst_n <= 1;
    rd_status();
    cfg_rd(DW_BUSNUM, 32'h0000_0000);
    @(posedge clk);
    global_reset_n_n <= 0;
    tick(4);
    global_reset_n_n <= 1;
    tick(3);
    st = 'h0200;
    rd_status();
    finish_test();
  end
endmodule // test_cardbus_secondary_status_busnum
`default_nettype wire
